// file: rtl/quadrature_encoder_control.v
`timescale 1ns/10ps
`include "qei_control_map.vh"
// Notes on behaviour
// - writing the counter enable bit (bit 15) as one lets the encoder counters run.
// - with the enable bit clear the counters stop but every register stays readable and the control, init and compare registers stay writable.
// - with the idle stop bit (bit 13) set the module halts while the device is in idle mode.
// - with the idle stop bit clear the module keeps running through idle mode.
// - bit 14 of the control register is unimplemented and always reads zero.
// - bits 12 to 10 select the position init mode, and code 111 is reserved and not to be used.
// - mode 110 runs the position counter in modulo mode.
// - mode 101 resets the position counter when it equals the greater-or-equal compare register.
// - mode 100 loads the init value on the second index after home, mode 011 on the first.
// - mode 010 loads the init value on the next index event.
// - mode 001 resets the counter on every index event, mode 000 ignores index events.
// - the phase b match bit picks the phase b level (high when set, low when clear) needed for an index match.
// - the phase a match bit (bit 8) picks the phase a level needed for an index match.
module quadrature_encoder_control (
    input  wire        clk,
    input  wire        rstn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire        idleMode,
    input  wire        phaseA,
    input  wire        phaseB,
    input  wire        indexPin,
    input  wire        homePin,
    output wire        counterRunning,
    output reg  [31:0] position
);
    // ----------------------------------------
    // registers and state
    // ----------------------------------------
    reg  [15:0] control;
    reg  [31:0] initValue;
    reg  [31:0] geCompare;
    reg  [1:0]  homeIndexCount;   // index events seen since last home
    reg         homeArmed;
    reg  [1:0]  prevAB;
    reg         loadDone;         // mode 010 loads once per arm
    reg  [2:0]  lastMode;
    reg  [31:0] next_position;

    wire        syncA;
    wire        syncB;
    wire        syncIndex;
    wire        indexRise;
    wire        syncHome;
    wire        homeRise;

    wire        writeStrobe = psel & penable & pwrite;
    wire        readAccess  = psel & ~pwrite;
    wire [2:0]  initMode    = control[`MODE_HI:`MODE_LO];

    // ----------------------------------------
    // address decode
    // ----------------------------------------
    function mapped;
        input [11:0] addr;
        begin
            mapped = (addr == `ADDR_CONTROL) || (addr == `ADDR_INITVAL) ||
                     (addr == `ADDR_GECMP) || (addr == `ADDR_POSITION) ||
                     (addr == `ADDR_STATUS);
        end
    endfunction

    // quadrature step direction: +1, -1 or 0 from old and new phase pair
    function [1:0] stepOf;
        input [1:0] oldAB;
        input [1:0] newAB;
        begin
            case ({oldAB, newAB})
                4'b0001, 4'b0111, 4'b1110, 4'b1000: stepOf = 2'b01;
                4'b0010, 4'b1011, 4'b1101, 4'b0100: stepOf = 2'b11;
                default:                            stepOf = 2'b00;
            endcase
        end
    endfunction

    // zero-wait slave; unmapped addresses answer with an error
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~mapped(paddr);

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    pin_sync syncPhaseA (
        .clk   (clk),
        .rstn  (rstn),
        .pin   (phaseA),
        .level (syncA),
        .rise  ()
    );
    pin_sync syncPhaseB (
        .clk   (clk),
        .rstn  (rstn),
        .pin   (phaseB),
        .level (syncB),
        .rise  ()
    );
    pin_sync syncIdx (
        .clk   (clk),
        .rstn  (rstn),
        .pin   (indexPin),
        .level (syncIndex),
        .rise  (indexRise)
    );
    pin_sync syncHm (
        .clk   (clk),
        .rstn  (rstn),
        .pin   (homePin),
        .level (syncHome),
        .rise  (homeRise)
    );

    // ----------------------------------------
    // run qualification
    // ----------------------------------------
    // idle only halts when the stop bit asks for it
    assign counterRunning = control[`BIT_ENABLE]
                          & ~(control[`BIT_IDLESTOP] & idleMode);

    // index counts only when both phases sit at the selected levels
    wire indexMatch = indexRise
                    & (syncB == control[`BIT_MATCHB])
                    & (syncA == control[`BIT_MATCHA]);
    wire [1:0] step = stepOf(prevAB, {syncA, syncB});

    // ----------------------------------------
    // register writes
    // ----------------------------------------
    // registers stay writable whatever the enable says
    always @(posedge clk) begin
        if (!rstn) begin
            control   <= `CTRL_RESET;
            initValue <= `POS_RESET;
            geCompare <= `POS_RESET;
        end else if (writeStrobe) begin
            case (paddr)
                `ADDR_CONTROL: control   <= pwdata[15:0] & `CTRL_WMASK;
                `ADDR_INITVAL: initValue <= pwdata;
                `ADDR_GECMP:   geCompare <= pwdata;
                default:       control   <= control;
            endcase
        end
    end

    // ----------------------------------------
    // read mux
    // ----------------------------------------
    always @(posedge clk) begin
        if (!rstn) begin
            prdata <= 32'h0000_0000;
        end else if (readAccess && !penable) begin
            case (paddr)
                `ADDR_CONTROL:  prdata <= {16'h0000, control};
                `ADDR_INITVAL:  prdata <= initValue;
                `ADDR_GECMP:    prdata <= geCompare;
                `ADDR_POSITION: prdata <= position;
                `ADDR_STATUS:   prdata <= {26'h000_0000, homeIndexCount, homeArmed,
                                           syncIndex, syncHome, counterRunning};
                default:        prdata <= 32'h0000_0000;
            endcase
        end
    end

    // ----------------------------------------
    // next position
    // ----------------------------------------
    // counting first, then index or compare actions override it
    always @* begin
        next_position = position;
        if (step == 2'b01) begin
            if (initMode == `MODE_MODULO && position >= geCompare) begin
                next_position = `POS_RESET;
            end else begin
                next_position = position + 32'h0000_0001;
            end
        end else if (step == 2'b11) begin
            if (initMode == `MODE_MODULO && position == `POS_RESET) begin
                next_position = geCompare;
            end else begin
                next_position = position - 32'h0000_0001;
            end
        end
        case (initMode)
            `MODE_RESET_IDX: begin
                if (indexMatch) next_position = `POS_RESET;
            end
            `MODE_LOAD_IDX: begin
                if (indexMatch && !loadDone) next_position = initValue;
            end
            `MODE_HOME_1ST: begin
                if (indexMatch && homeArmed && homeIndexCount == 2'd0)
                    next_position = initValue;
            end
            `MODE_HOME_2ND: begin
                if (indexMatch && homeArmed && homeIndexCount == 2'd1)
                    next_position = initValue;
            end
            `MODE_GE_RESET: begin
                if (position == geCompare) next_position = `POS_RESET;
            end
            default: begin
                next_position = next_position;
            end
        endcase
    end

    // ----------------------------------------
    // counter and event tracking
    // ----------------------------------------
    // halted counters freeze position and home tracking, so no event is half taken; prevAB and lastMode still update
    always @(posedge clk) begin
        if (!rstn) begin
            position       <= `POS_RESET;
            homeArmed      <= 1'b0;
            homeIndexCount <= 2'd0;
            prevAB         <= 2'b00;
            loadDone       <= 1'b0;
            lastMode       <= `MODE_NONE;
        end else begin
            prevAB   <= {syncA, syncB};     // tracked always so restart sees no false step
            lastMode <= initMode;
            if (initMode != lastMode) begin
                loadDone <= 1'b0;
            end
            if (counterRunning) begin
                position <= next_position;
                if (indexMatch && initMode == `MODE_LOAD_IDX) begin
                    loadDone <= 1'b1;
                end
                if (homeRise) begin
                    homeArmed      <= 1'b1;
                    homeIndexCount <= 2'd0;
                end else if (indexMatch && homeArmed) begin
                    if (homeIndexCount == 2'd1 || initMode == `MODE_HOME_1ST) begin
                        homeArmed <= 1'b0;
                    end
                    homeIndexCount <= homeIndexCount + 2'd1;
                end
            end
        end
    end
endmodule

// file: rtl/qei_control_map.vh
`ifndef QEI_CONTROL_MAP_VH
`define QEI_CONTROL_MAP_VH
// ----------------------------------------
// register addresses (byte offsets on apb)
// ----------------------------------------
`define ADDR_CONTROL    12'h000
`define ADDR_INITVAL    12'h004
`define ADDR_GECMP      12'h008
`define ADDR_POSITION   12'h00C
`define ADDR_STATUS     12'h010
// ----------------------------------------
// control field positions
// ----------------------------------------
`define BIT_ENABLE      15
`define BIT_RSVD14      14
`define BIT_IDLESTOP    13
`define MODE_HI         12
`define MODE_LO         10
`define BIT_MATCHB      9
`define BIT_MATCHA      8
`define CTRL_WMASK      16'hBF00
`define CTRL_RESET      16'h0000
`define POS_RESET       32'h0000_0000
// ----------------------------------------
// initialization mode codes
// ----------------------------------------
`define MODE_NONE       3'h0
`define MODE_RESET_IDX  3'h1
`define MODE_LOAD_IDX   3'h2
`define MODE_HOME_1ST   3'h3
`define MODE_HOME_2ND   3'h4
`define MODE_GE_RESET   3'h5
`define MODE_MODULO     3'h6
`define MODE_RESERVED   3'h7
`endif

// file: rtl/pin_sync.v
`timescale 1ns/10ps
// two-stage synchroniser for asynchronous pins, with rising-edge pulse
module pin_sync (
    input  wire clk,
    input  wire rstn,
    input  wire pin,
    output reg  level,
    output wire rise
);
    reg stage1;
    reg levelQ;

    // ----------------------------------------
    // synchroniser chain
    // ----------------------------------------
    // stage1 feeds only level; edge detection looks at later stages
    always @(posedge clk) begin
        if (!rstn) begin
            stage1 <= 1'b0;
            level  <= 1'b0;
            levelQ <= 1'b0;
        end else begin
            stage1 <= pin;
            level  <= stage1;
            levelQ <= level;
        end
    end

    assign rise = level & ~levelQ;
endmodule

// file: verification/qei_control_properties.sv
`timescale 1ns/10ps
`include "qei_control_map.vh"
// --------
// control register checks
// --------
module qei_control_properties (
    input wire        clk,
    input wire        rstn,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire        idleMode,
    input wire        counterRunning,
    input wire [31:0] position
);
    reg  [15:0] ctl;
    reg  [31:0] ge;
    wire        wr = psel & penable & pwrite;
    wire        rdc = psel & ~penable & ~pwrite & (paddr == `ADDR_CONTROL);
    wire [2:0]  md = ctl[12:10];
    // shadow copies, so checks do not trust the readback they test
    always @(posedge clk) begin
        if (!rstn) begin
            ctl <= 16'h0000;
            ge <= 32'h0000_0000;
        end else if (wr && paddr == `ADDR_CONTROL) begin
            ctl <= pwdata[15:0] & `CTRL_WMASK;
        end else if (wr && paddr == `ADDR_GECMP) begin
            ge <= pwdata;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    chk_enable_run: assert property (ctl[15] && !idleMode |-> counterRunning)
        else $error("enabled counter not running");
    chk_disable_stop: assert property (!ctl[15] |-> !counterRunning)
        else $error("disabled counter running");
    chk_idle_halt: assert property (ctl[13] && idleMode |-> !counterRunning)
        else $error("counter runs in idle");
    chk_idle_run: assert property (ctl[15] && !ctl[13] |-> counterRunning)
        else $error("counter halted in idle");
    chk_bit14_zero: assert property (rdc |=> !prdata[14])
        else $error("unimplemented bit reads one");
    chk_ctl_readback: assert property (rdc |=> prdata == {16'h0000, $past(ctl)})
        else $error("control readback wrong");
    chk_stop_hold: assert property (!counterRunning |=> $stable(position))
        else $error("position moved while stopped");
    // in modes 000 and 001, one step at most per cycle; only an index reset may jump, to zero
    chk_index_step: assert property (counterRunning && md <= 3'h1 |=>
        position == 32'h0000_0000 && $past(md) == 3'h1 || position - $past(position) + 32'h1 <= 32'h2)
        else $error("position jumped");
    chk_modulo_bound: assert property (counterRunning && md == 3'h6 && position <= ge |=> position <= ge)
        else $error("modulo count left range");
    cov_modulo: cover property (counterRunning && md == 3'h6 && position == ge);
    cov_idle: cover property (ctl[15] && ctl[13] && idleMode);
    cov_load: cover property (md == 3'h2 && $changed(position));
endmodule
bind quadrature_encoder_control qei_control_properties u_props (
    .clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .idleMode(idleMode), .counterRunning(counterRunning),
    .position(position));

// file: verification/qei_encoder_model.sv
`timescale 1ns/10ps
// --------
// incremental encoder with index and home
// --------
module qei_encoder_model (
    input  wire  clk,
    output logic phaseA,
    output logic phaseB,
    output logic indexPin,
    output logic homePin
);
    logic [1:0] st;
    initial begin
        st = 2'd0;
        {phaseA, phaseB, indexPin, homePin} = 4'h0;
    end
    // one gray step ({a,b} 00,01,11,10 counts up), then gap clocks quiet;
    // gap below 2 outruns the pin synchronisers
    task step(input logic up, input int gap);
        @(posedge clk);
        st = up ? st + 2'd1 : st - 2'd1;
        phaseA <= st[1];
        phaseB <= st[1] ^ st[0];
        repeat (gap - 1) @(posedge clk);
    endtask
    // index (sel 0) or home (sel 1) pulse, phases held still meanwhile
    task pulse(input logic sel);
        @(posedge clk);
        if (sel) homePin <= 1'b1;
        else indexPin <= 1'b1;
        repeat (4) @(posedge clk);
        homePin <= 1'b0;
        indexPin <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
endmodule

// file: verification/tb_quadrature_encoder_control.sv
`timescale 1ns/10ps
`include "qei_control_map.vh"
// --------
// register and encoder scenarios
// --------
module tb_quadrature_encoder_control;
    logic        clk;
    logic        rstn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic        idleMode;
    logic        err;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] rd;
    wire  [31:0] prdata;
    wire  [31:0] position;
    wire         pready, pslverr, counterRunning, phaseA, phaseB, indexPin, homePin;
    int          num_errors;
    int          total_checks;
    quadrature_encoder_control u_dut (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .idleMode(idleMode), .phaseA(phaseA), .phaseB(phaseB),
        .indexPin(indexPin), .homePin(homePin), .counterRunning(counterRunning), .position(position));
    qei_encoder_model u_enc (.clk(clk), .phaseA(phaseA), .phaseB(phaseB), .indexPin(indexPin),
        .homePin(homePin));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task summarize;
        if (num_errors == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // one apb transfer; read data and error taken at the pready edge
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        {psel, penable, pwrite} <= {2'b10, w};
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
        if (n >= 16) begin
            num_errors++;
            summarize();
        end
    endtask
    // match bits follow the present phase levels unless flipped by x; reserved mode 111 is never picked
    task wc(input logic [15:0] hi, input logic [2:0] md, input logic [1:0] x);
        apb(1'b1, `ADDR_CONTROL, {16'h0000, hi | {3'b000, md, {phaseB, phaseA} ^ x, 8'h00}});
    endtask
    task mv(input logic up, input int n, input int gap, input logic [31:0] e);
        repeat (n) u_enc.step(up, gap);
        repeat (3) @(posedge clk);
        chk(position, e);
    endtask
    task ix(input logic sel, input logic [31:0] e);
        u_enc.pulse(sel);
        chk(position, e);
    endtask
    initial begin
        {rstn, psel, penable, pwrite, idleMode} = 5'b00000;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        num_errors = 0;
        total_checks = 0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        apb(1'b0, `ADDR_CONTROL, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        apb(1'b0, 12'h100, 32'h0000_0000);
        chk({31'h0000_0000, err}, 32'h0000_0001);
        apb(1'b1, `ADDR_CONTROL, 32'h0000_FB00);
        apb(1'b0, `ADDR_CONTROL, 32'h0000_0000);
        chk(rd, 32'h0000_BB00);
        wc(16'h8000, 3'h0, 2'b00);
        mv(1'b1, 5, 3, 32'h0000_0005);
        mv(1'b0, 1, 8, 32'h0000_0004);
        ix(1'b0, 32'h0000_0004);
        wc(16'h0000, 3'h1, 2'b00);
        mv(1'b1, 1, 3, 32'h0000_0004);
        ix(1'b0, 32'h0000_0004);
        apb(1'b1, `ADDR_INITVAL, 32'h0000_0055);
        apb(1'b0, `ADDR_INITVAL, 32'h0000_0000);
        chk(rd, 32'h0000_0055);
        wc(16'hA000, 3'h0, 2'b00);
        idleMode <= 1'b1;
        mv(1'b1, 1, 3, 32'h0000_0004);
        wc(16'h8000, 3'h0, 2'b00);
        mv(1'b1, 1, 3, 32'h0000_0005);
        idleMode <= 1'b0;
        // each match bit wrong on its own must block the index
        for (int k = 1; k < 3; k++) begin
            wc(16'h8000, 3'h1, k[1:0]);
            ix(1'b0, 32'h0000_0005);
        end
        wc(16'h8000, 3'h1, 2'b00);
        ix(1'b0, 32'h0000_0000);
        // step before arming, so the match bits see the phase levels the index will meet
        mv(1'b1, 1, 3, 32'h0000_0001);
        wc(16'h8000, 3'h2, 2'b00);
        ix(1'b0, 32'h0000_0055);
        apb(1'b1, `ADDR_INITVAL, 32'h0000_0022);
        wc(16'h8000, 3'h3, 2'b00);
        u_enc.pulse(1'b1);
        ix(1'b0, 32'h0000_0022);
        apb(1'b1, `ADDR_INITVAL, 32'h0000_0033);
        wc(16'h8000, 3'h4, 2'b00);
        u_enc.pulse(1'b1);
        ix(1'b0, 32'h0000_0022);
        ix(1'b0, 32'h0000_0033);
        wc(16'h8000, 3'h1, 2'b00);
        ix(1'b0, 32'h0000_0000);
        apb(1'b1, `ADDR_GECMP, 32'h0000_0003);
        wc(16'h8000, 3'h5, 2'b00);
        mv(1'b1, 3, 4, 32'h0000_0000);
        wc(16'h8000, 3'h6, 2'b00);
        mv(1'b0, 1, 3, 32'h0000_0003);
        mv(1'b1, 1, 3, 32'h0000_0000);
        summarize();
    end
endmodule
